// *** loop_pma_pkg.sv ***
// shared constants, types and register map of the loopback and pma mode control
package loop_pma_pkg;

    // ==========================================
    // register map (byte addresses)
    localparam logic [7:0] LOOP_CTRL_OFS = 8'h00;
    localparam logic [7:0] PMA_CTRL_OFS = 8'h04;
    localparam logic [7:0] PCS_TYPE_OFS = 8'h08;
    localparam logic [7:0] PCS_MODE_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // ==========================================
    // reset values and writable masks
    localparam logic [15:0] LOOP_CTRL_RST = 16'h0400;
    localparam logic [15:0] LOOP_CTRL_WMASK = 16'h0FFF;
    localparam logic [15:0] PMA_CTRL_RST = 16'h0001;
    localparam logic [15:0] PMA_CTRL_WMASK = 16'h01FF;
    localparam logic PCS_TYPE_RST = 1'h0;
    localparam logic [1:0] PCS_MODE_RST = 2'h0;
    localparam logic [1:0] PCS_MODE_WAN = 2'h2;

    // ==========================================
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ==========================================
    // data words
    localparam int WORD_W = 64;
    localparam logic [63:0] IDLE_PATTERN = 64'h00FF00FF00FF00FF;
    localparam logic [63:0] ALL_ZEROS = 64'h0000000000000000;
    localparam logic [63:0] ALL_ONES = 64'hFFFFFFFFFFFFFFFF;

    // ==========================================
    // loop enable vector positions
    localparam int LB_A = 0;
    localparam int LB_B = 1;
    localparam int LB_C = 2;
    localparam int LB_D = 3;
    localparam int LB_E = 4;
    localparam int LB_F = 5;
    localparam int LB_G = 6;
    localparam int LB_H = 7;
    localparam int LB_J = 8;
    localparam int LB_K = 9;
    localparam int NUM_LOOPS = 10;

    // ==========================================
    // synchronised pin positions and values after reset
    localparam int PIN_SPLIT = 0;
    localparam int PIN_TENBIT = 1;
    localparam int PIN_SIXTEEN = 2;
    localparam int PIN_SPLIT_N = 3;
    localparam int PIN_TX_EN = 4;
    localparam int PIN_REF_RATE = 5;
    localparam int PIN_WAN_SEL = 6;
    localparam int NUM_PINS = 7;
    localparam logic [6:0] PIN_RST = 7'h18;

    // ==========================================
    // types
    typedef struct packed {
        logic [3:0] rsvd;
        logic xs_rx_sigdet_ovr;
        logic pma_net_loop_disable;
        logic wis_sys_loop;
        logic pma_sys_loop;
        logic wis_net_loop;
        logic pcs_sys_loop;
        logic gearbox_net_loop;
        logic pcs_fifo_sys_loop;
        logic shallow_net_loop;
        logic deep_sys_loop;
        logic shallow_sys_loop;
        logic deep_net_loop;
    } loop_ctrl_t;

    typedef struct packed {
        logic [6:0] rsvd;
        logic [1:0] tx_src_sel;
        logic serial_tx_source_override;
        logic wan_select_force;
        logic wan_select_override;
        logic wan_ref_rate_force;
        logic wan_ref_rate_override;
        logic linetiming_force;
        logic tx_bit_order_sel;
    } pma_ctrl_t;

    typedef enum logic [1:0] {
        SRC_PATTERN = 2'h0,
        SRC_ZEROS = 2'h1,
        SRC_ONES = 2'h2,
        SRC_NORMAL = 2'h3
    } tx_src_t;

    typedef enum logic [1:0] {
        RT_LAN = 2'h0,
        RT_WAN = 2'h1,
        RT_LINE = 2'h2
    } retime_src_t;

    typedef enum logic [2:0] {
        REG_LOOP = 3'h0,
        REG_PMA = 3'h1,
        REG_TYPE = 3'h2,
        REG_MODE = 3'h3,
        REG_STAT = 3'h4,
        REG_NONE = 3'h7
    } reg_sel_t;

endpackage

// *** loop_pma_ctrl.sv ***
// loopback selection and pma mode control with an axi4-lite register slave
// Contract
// - deep net loop: deep bit set, shallow clear
// - loop A mirrors rx; off with split pin
// - shallow sys loop: bit, 10b or split pin
// - deep sys loop returns xaui, forwards xfi
// - shallow net loop: bit, both, split pin
// - pcs fifo loop sends 00FF on xfi
// - gearbox net loop returns rx, mirrors egress
// - pcs sys loop: bit or 16b pin, 00FF
// - wis net loop returns and mirrors rx
// - pma/wis sys loop: bits or pin low
// - pma net loop: bit low or pin low
// - split pin high enables B and D
// - split pin low enables J and K
// - transmitter takes 64-bit parallel words
// - bit order resets to lsb first
// - tx enable pin low mutes output
// - linetime force resets 0, status reports it
// - ref rate from pin unless overridden
// - wan status from pin, type, mode, override
// - pcs type/mode writes raise controller interrupt
// - system loop xfi source override field
// - retime clock from wan and linetime status
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module loop_pma_ctrl
    import loop_pma_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic xaui_split_loop_pin,
    input wire logic tenbit_loop_pin,
    input wire logic sixteenbit_loop_pin,
    input wire logic pma_split_loop_pin_n,
    input wire logic serial_tx_enable_pin,
    input wire logic wan_ref_rate_pin,
    input wire logic wan_select_pin,
    input wire logic [WORD_W-1:0] pcs_tx_word,
    input wire logic pcs_tx_valid,
    input wire logic [WORD_W-1:0] pcs_rx_word,
    input wire logic [WORD_W-1:0] xaui_rx_word,
    input wire logic [WORD_W-1:0] serial_rx_word,
    output logic [WORD_W-1:0] serial_tx_out,
    output logic serial_tx_valid,
    output logic [WORD_W-1:0] xaui_egress_lanes,
    output logic [NUM_LOOPS-1:0] loop_en,
    output retime_src_t retime_src,
    output logic xaui_retime_recovered,
    output logic xaui_rx_sigdet_force,
    output logic linetime_status,
    output logic wan_active_status,
    output logic wan_ref_rate_status,
    output logic wan_ref_rate_pin_state,
    output logic wan_select_pin_state,
    output logic uc_irq
);

    // ==========================================
    // helpers
    function automatic reg_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = REG_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr[7:0])
                LOOP_CTRL_OFS: sel = REG_LOOP;
                PMA_CTRL_OFS: sel = REG_PMA;
                PCS_TYPE_OFS: sel = REG_TYPE;
                PCS_MODE_OFS: sel = REG_MODE;
                STATUS_OFS: sel = REG_STAT;
                default: sel = REG_NONE;
            endcase
        end
        return sel;
    endfunction

    function automatic logic [WORD_W-1:0] bit_reverse(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] r;
        r = '0;
        for (int i = 0; i < WORD_W; i++) begin
            r[i] = w[WORD_W-1-i];
        end
        return r;
    endfunction

    // ==========================================
    // pin synchronisers
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_meta_r;
    logic [NUM_PINS-1:0] pin_r;

    assign pin_raw = {wan_select_pin, wan_ref_rate_pin, serial_tx_enable_pin,
        pma_split_loop_pin_n, sixteenbit_loop_pin, tenbit_loop_pin, xaui_split_loop_pin};

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin_sync
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    pin_meta_r[gp] <= PIN_RST[gp];
                    pin_r[gp] <= PIN_RST[gp];
                end else begin
                    pin_meta_r[gp] <= pin_raw[gp];
                    pin_r[gp] <= pin_meta_r[gp];
                end
            end
        end
    endgenerate

    // ==========================================
    // register slave
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;

    wr_state_t wr_state_r, wr_state_nxt;
    rd_state_t rd_state_r, rd_state_nxt;
    loop_ctrl_t loop_ctrl_r, loop_ctrl_nxt;
    pma_ctrl_t pma_ctrl_r, pma_ctrl_nxt;
    logic pcs_type_r, pcs_type_nxt;
    logic [1:0] pcs_mode_r, pcs_mode_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic irq_r, irq_nxt;
    logic wr_fire;
    logic [15:0] wmask;
    logic [15:0] wval;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic [15:0] status_word;

    assign wr_fire = (wr_state_r == WR_IDLE) && s_axi_awvalid && s_axi_wvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign s_axi_bvalid = (wr_state_r == WR_RESP);
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = (rd_state_r == RD_IDLE);
    assign s_axi_rvalid = (rd_state_r == RD_RESP);
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign wr_sel = reg_decode(s_axi_awaddr);
    assign rd_sel = reg_decode(s_axi_araddr);
    assign wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wval = s_axi_wdata[15:0];

    always_comb begin
        wr_state_nxt = wr_state_r;
        loop_ctrl_nxt = loop_ctrl_r;
        pma_ctrl_nxt = pma_ctrl_r;
        pcs_type_nxt = pcs_type_r;
        pcs_mode_nxt = pcs_mode_r;
        bresp_nxt = bresp_r;
        irq_nxt = 1'b0;
        unique case (wr_state_r)
            WR_IDLE: begin
                if (wr_fire) begin
                    wr_state_nxt = WR_RESP;
                    bresp_nxt = (wr_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
                    unique case (wr_sel)
                        REG_LOOP: loop_ctrl_nxt = loop_ctrl_t'((loop_ctrl_r & ~(wmask
                            & LOOP_CTRL_WMASK)) | (wval & wmask & LOOP_CTRL_WMASK));
                        REG_PMA: pma_ctrl_nxt = pma_ctrl_t'((pma_ctrl_r & ~(wmask
                            & PMA_CTRL_WMASK)) | (wval & wmask & PMA_CTRL_WMASK));
                        REG_TYPE: begin
                            if (s_axi_wstrb[0]) begin
                                pcs_type_nxt = wval[0];
                            end
                            irq_nxt = 1'b1;
                        end
                        REG_MODE: begin
                            if (s_axi_wstrb[0]) begin
                                pcs_mode_nxt = wval[1:0];
                            end
                            irq_nxt = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_nxt = WR_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        rd_state_nxt = rd_state_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        unique case (rd_state_r)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_state_nxt = RD_RESP;
                    rresp_nxt = (rd_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
                    unique case (rd_sel)
                        REG_LOOP: rdata_nxt = {16'h0000, loop_ctrl_r};
                        REG_PMA: rdata_nxt = {16'h0000, pma_ctrl_r};
                        REG_TYPE: rdata_nxt = {31'h00000000, pcs_type_r};
                        REG_MODE: rdata_nxt = {30'h00000000, pcs_mode_r};
                        REG_STAT: rdata_nxt = {16'h0000, status_word};
                        default: rdata_nxt = 32'h00000000;
                    endcase
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    rd_state_nxt = RD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_state_r <= WR_IDLE;
            rd_state_r <= RD_IDLE;
            loop_ctrl_r <= LOOP_CTRL_RST;
            pma_ctrl_r <= PMA_CTRL_RST;
            pcs_type_r <= PCS_TYPE_RST;
            pcs_mode_r <= PCS_MODE_RST;
            bresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
            irq_r <= 1'b0;
        end else begin
            wr_state_r <= wr_state_nxt;
            rd_state_r <= rd_state_nxt;
            loop_ctrl_r <= loop_ctrl_nxt;
            pma_ctrl_r <= pma_ctrl_nxt;
            pcs_type_r <= pcs_type_nxt;
            pcs_mode_r <= pcs_mode_nxt;
            bresp_r <= bresp_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign uc_irq = irq_r;

    // ==========================================
    // loop enables and mode status
    logic split_hi;
    logic split_lo;
    logic [NUM_LOOPS-1:0] loop_en_nxt;
    logic [NUM_LOOPS-1:0] loop_en_r;
    logic wan_nxt;
    logic rate_nxt;
    retime_src_t retime_nxt;
    logic [4:0] mode_r;

    assign split_hi = pin_r[PIN_SPLIT];
    assign split_lo = !pin_r[PIN_SPLIT_N];

    always_comb begin
        loop_en_nxt = '0;
        loop_en_nxt[LB_A] = loop_ctrl_r.deep_net_loop && !loop_ctrl_r.shallow_sys_loop
            && !split_hi;
        loop_en_nxt[LB_B] = loop_ctrl_r.shallow_sys_loop || pin_r[PIN_TENBIT]
            || split_hi;
        loop_en_nxt[LB_C] = loop_ctrl_r.deep_sys_loop;
        loop_en_nxt[LB_D] = loop_ctrl_r.shallow_net_loop || (loop_ctrl_r.deep_net_loop
            && loop_ctrl_r.shallow_sys_loop) || split_hi;
        loop_en_nxt[LB_E] = loop_ctrl_r.pcs_fifo_sys_loop;
        loop_en_nxt[LB_F] = loop_ctrl_r.gearbox_net_loop;
        loop_en_nxt[LB_G] = loop_ctrl_r.pcs_sys_loop || pin_r[PIN_SIXTEEN];
        loop_en_nxt[LB_H] = loop_ctrl_r.wis_net_loop;
        loop_en_nxt[LB_J] = loop_ctrl_r.pma_sys_loop || loop_ctrl_r.wis_sys_loop
            || split_lo;
        loop_en_nxt[LB_K] = !loop_ctrl_r.pma_net_loop_disable || split_lo;
        rate_nxt = pma_ctrl_r.wan_ref_rate_override ? pma_ctrl_r.wan_ref_rate_force
            : pin_r[PIN_REF_RATE];
        wan_nxt = pma_ctrl_r.wan_select_override ? pma_ctrl_r.wan_select_force
            : (pin_r[PIN_WAN_SEL] || pcs_type_r || (pcs_mode_r == PCS_MODE_WAN));
        if (pma_ctrl_r.linetiming_force) begin
            retime_nxt = RT_LINE;
        end else if (wan_nxt) begin
            retime_nxt = RT_WAN;
        end else begin
            retime_nxt = RT_LAN;
        end
        // split loop D without loop K retimes from the local reference, ignoring linetiming
        if (split_hi && !loop_en_nxt[LB_K]) begin
            retime_nxt = wan_nxt ? RT_WAN : RT_LAN;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            loop_en_r <= '0;
            mode_r <= 5'h00;
            retime_src <= RT_LAN;
        end else begin
            loop_en_r <= loop_en_nxt;
            mode_r <= {pin_r[PIN_WAN_SEL], pin_r[PIN_REF_RATE], rate_nxt, wan_nxt,
                pma_ctrl_r.linetiming_force};
            retime_src <= retime_nxt;
        end
    end

    assign loop_en = loop_en_r;
    assign linetime_status = mode_r[0];
    assign wan_active_status = mode_r[1];
    assign wan_ref_rate_status = mode_r[2];
    assign wan_ref_rate_pin_state = mode_r[3];
    assign wan_select_pin_state = mode_r[4];
    assign xaui_rx_sigdet_force = loop_ctrl_r.xs_rx_sigdet_ovr;
    assign xaui_retime_recovered = loop_en_r[LB_B];
    assign status_word = {1'b0, mode_r, loop_en_r};

    // ==========================================
    // datapath steering
    logic net_loop;
    logic sys_pattern_loop;
    logic sys_mirror_loop;
    logic [WORD_W-1:0] tx_word;
    logic [WORD_W-1:0] tx_nxt;
    logic [WORD_W-1:0] egress_nxt;
    logic [WORD_W-1:0] tx_out_r;
    logic tx_valid_r;
    logic [WORD_W-1:0] egress_r;

    assign net_loop = loop_en_r[LB_A] || loop_en_r[LB_D] || loop_en_r[LB_F]
        || loop_en_r[LB_H] || loop_en_r[LB_K];
    assign sys_pattern_loop = loop_en_r[LB_E] || loop_en_r[LB_G] || loop_en_r[LB_J];
    assign sys_mirror_loop = loop_en_r[LB_B] || loop_en_r[LB_C];

    always_comb begin
        tx_word = pcs_tx_word;
        if (net_loop) begin
            tx_word = serial_rx_word;
        end else if (sys_pattern_loop || sys_mirror_loop) begin
            if (pma_ctrl_r.serial_tx_source_override) begin
                unique case (tx_src_t'(pma_ctrl_r.tx_src_sel))
                    SRC_PATTERN: tx_word = IDLE_PATTERN;
                    SRC_ZEROS: tx_word = ALL_ZEROS;
                    SRC_ONES: tx_word = ALL_ONES;
                    SRC_NORMAL: tx_word = pcs_tx_word;
                endcase
            end else if (sys_pattern_loop) begin
                tx_word = IDLE_PATTERN;
            end
        end
        if (!pin_r[PIN_TX_EN]) begin
            tx_nxt = ALL_ZEROS;
        end else if (pma_ctrl_r.tx_bit_order_sel) begin
            tx_nxt = tx_word;
        end else begin
            tx_nxt = bit_reverse(tx_word);
        end
        egress_nxt = pcs_rx_word;
        if (sys_mirror_loop || sys_pattern_loop) begin
            egress_nxt = xaui_rx_word;
        end else if (net_loop) begin
            egress_nxt = serial_rx_word;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tx_out_r <= ALL_ZEROS;
            tx_valid_r <= 1'b0;
            egress_r <= ALL_ZEROS;
        end else begin
            tx_out_r <= tx_nxt;
            tx_valid_r <= pcs_tx_valid || net_loop || sys_pattern_loop;
            egress_r <= egress_nxt;
        end
    end

    assign serial_tx_out = tx_out_r;
    assign serial_tx_valid = tx_valid_r;
    assign xaui_egress_lanes = egress_r;

    // ==========================================
    // assertions
    property p_deep_net_gate;
        @(posedge mclk) disable iff (reset)
        loop_en[LB_A] |-> $past(loop_ctrl_r.deep_net_loop) && !$past(split_hi)
            && !$past(loop_ctrl_r.shallow_sys_loop);
    endproperty
    a_deep_net_gate: assert property (p_deep_net_gate)
        else $error("deep net loop active without its controls");

    property p_split_hi;
        @(posedge mclk) disable iff (reset)
        split_hi |=> loop_en[LB_B] && loop_en[LB_D] && !loop_en[LB_A];
    endproperty
    a_split_hi: assert property (p_split_hi)
        else $error("split pin high did not enable B and D");

    property p_split_lo;
        @(posedge mclk) disable iff (reset)
        split_lo |=> loop_en[LB_J] && loop_en[LB_K];
    endproperty
    a_split_lo: assert property (p_split_lo)
        else $error("split pin low did not enable J and K");

    property p_mute;
        @(posedge mclk) disable iff (reset)
        !pin_r[PIN_TX_EN] |=> serial_tx_out == ALL_ZEROS;
    endproperty
    a_mute: assert property (p_mute)
        else $error("serial output not muted");

    property p_pattern;
        @(posedge mclk) disable iff (reset)
        sys_pattern_loop && !net_loop && pin_r[PIN_TX_EN]
            && !pma_ctrl_r.serial_tx_source_override && pma_ctrl_r.tx_bit_order_sel
            |=> serial_tx_out == IDLE_PATTERN;
    endproperty
    a_pattern: assert property (p_pattern)
        else $error("system loop did not send idle pattern");

    property p_net_return;
        @(posedge mclk) disable iff (reset)
        loop_en[LB_K] && pin_r[PIN_TX_EN] && pma_ctrl_r.tx_bit_order_sel
            |=> serial_tx_out == $past(serial_rx_word);
    endproperty
    a_net_return: assert property (p_net_return)
        else $error("network loop did not return rx word");

    property p_irq;
        @(posedge mclk) disable iff (reset)
        wr_fire && (wr_sel == REG_TYPE || wr_sel == REG_MODE) |=> uc_irq ##1 !uc_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("pcs type or mode write gave no single interrupt pulse");

    property p_ref_rate;
        @(posedge mclk) disable iff (reset)
        !pma_ctrl_r.wan_ref_rate_override && $stable(pma_ctrl_r)
            |=> wan_ref_rate_status == $past(pin_r[PIN_REF_RATE]);
    endproperty
    a_ref_rate: assert property (p_ref_rate)
        else $error("reference rate status does not follow pin");

    property p_retime_line;
        @(posedge mclk) disable iff (reset)
        linetime_status && $stable(pma_ctrl_r) && !split_hi |=> retime_src == RT_LINE;
    endproperty
    a_retime_line: assert property (p_retime_line)
        else $error("linetiming did not select recovered clock");

    property p_bit_order_reset;
        @(posedge mclk)
        $fell(reset) |-> pma_ctrl_r.tx_bit_order_sel && !pma_ctrl_r.linetiming_force;
    endproperty
    a_bit_order_reset: assert property (p_bit_order_reset)
        else $error("pma control reset value wrong");

endmodule

// *** far_end_words.sv ***
// word source standing in for the host mac and the optical module
`timescale 1ns/1ps
module far_end_words
    import loop_pma_pkg::*;
(
    input wire logic mclk,
    output logic [WORD_W-1:0] tx_word,
    output logic [WORD_W-1:0] rx_word,
    output logic [WORD_W-1:0] xaui_word,
    output logic [WORD_W-1:0] serial_word
);
    logic [15:0] cnt_r = 16'h0;
    always @(posedge mclk) cnt_r <= cnt_r + 16'h1;
    assign tx_word = {4{cnt_r}} ^ 64'h0123456789ABCDEF;
    assign rx_word = {cnt_r, 16'hA5A5, cnt_r, 16'h5A5A};
    assign xaui_word = ~tx_word;
    // pointer field held fixed
    assign serial_word = {16'h020A, cnt_r, 16'hC3C3, ~cnt_r};
endmodule

// *** loop_pma_ctrl_tb.sv ***
// self-checking bench of the loopback and pma mode control
`timescale 1ns/1ps
module loop_pma_ctrl_tb;
import loop_pma_pkg::*;
logic mclk = 0, reset = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, irq;
logic [7:0] awa = 0, ara = 0;
logic [31:0] wd = 0, rdat;
logic [1:0] rsp;
logic [6:0] pin = PIN_RST;
logic [63:0] txw, rxw, xrw, srw, p, sto, egr;
logic awr, bv, arr, rv, uirq, wan, wrr, sdf, xrr, lts, rrs, rps, wps, stv;
logic [1:0] br, rr, rts;
logic [31:0] rdd;
logic [9:0] len;
int num_errors = 0, cmp_count = 0;
logic [15:0] cv [10] = '{16'h0409, 16'h0403, 16'h0C04, 16'h0410, 16'h0420, 16'h0440,
    16'h0480, 16'h0500, 16'h0600, 16'h0000};
logic [9:0] ev [10] = '{10'h009, 10'h00A, 10'h004, 10'h010, 10'h020, 10'h040, 10'h080,
    10'h100, 10'h100, 10'h200};
logic [6:0] pv [4] = '{7'h39, 7'h5A, 7'h7C, 7'h10};
logic [9:0] pe [4] = '{10'h00A, 10'h003, 10'h041, 10'h301};
always #5 mclk = ~mclk;
far_end_words i_far (.mclk(mclk), .tx_word(txw), .rx_word(rxw), .xaui_word(xrw),
    .serial_word(srw));
loop_pma_ctrl i_dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .xaui_split_loop_pin(pin[PIN_SPLIT]),
    .tenbit_loop_pin(pin[PIN_TENBIT]), .sixteenbit_loop_pin(pin[PIN_SIXTEEN]),
    .pma_split_loop_pin_n(pin[PIN_SPLIT_N]), .serial_tx_enable_pin(pin[PIN_TX_EN]),
    .wan_ref_rate_pin(pin[PIN_REF_RATE]), .wan_select_pin(pin[PIN_WAN_SEL]),
    .pcs_tx_word(txw), .pcs_tx_valid(1'b1), .pcs_rx_word(rxw), .xaui_rx_word(xrw),
    .serial_rx_word(srw), .serial_tx_out(sto), .serial_tx_valid(stv), .xaui_egress_lanes(egr),
    .loop_en(len), .retime_src(rts), .xaui_retime_recovered(xrr), .xaui_rx_sigdet_force(sdf),
    .linetime_status(lts), .wan_active_status(wan), .wan_ref_rate_status(rrs),
    .wan_ref_rate_pin_state(rps), .wan_select_pin_state(wps), .uc_irq(uirq));
task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
        num_errors++;
        $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
endtask
task automatic nx(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    do @(negedge mclk); while (awr !== 1'b1 || wrr !== 1'b1);
    @(posedge mclk);
    awv <= 0; wv <= 0;
    do @(negedge mclk); while (bv !== 1'b1);
    irq = uirq;
    rsp = br;
    @(posedge mclk);
    bry <= 0;
endtask
task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    ara <= a; arv <= 1; rry <= 1;
    do @(negedge mclk); while (arr !== 1'b1);
    @(posedge mclk);
    arv <= 0;
    do @(negedge mclk); while (rv !== 1'b1);
    rdat = rdd; rsp = rr;
    @(posedge mclk);
    rry <= 0;
endtask
task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task automatic t_reset;
    rd(LOOP_CTRL_OFS); chk(rdat, 64'h400);
    rd(PMA_CTRL_OFS); chk(rdat, 64'h1);
    rd(8'h14); chk(rsp, RESP_DECERR);
    wr(8'h14, 32'h0000FFFF); chk(rsp, RESP_DECERR);
    chk(len, 64'h0);
endtask
task automatic t_regs;
    for (int i = 0; i < 10; i++) begin
        wr(LOOP_CTRL_OFS, {16'h0, cv[i]}); nx(3); chk(len, ev[i]);
        chk(sdf, cv[i][11]);
    end
endtask
task automatic t_pins;
    wr(LOOP_CTRL_OFS, 32'h0401);
    for (int i = 0; i < 4; i++) begin
        @(posedge mclk); pin <= pv[i]; nx(5); chk(len, pe[i]);
        chk(xrr, pe[i][LB_B]);
        chk({wan, wps}, {2{pv[i][PIN_WAN_SEL]}});
        chk({rps, rrs}, {2{pv[i][PIN_REF_RATE]}});
    end
    @(posedge mclk); pin <= PIN_RST;
    wr(LOOP_CTRL_OFS, 32'h0400);
endtask
task automatic t_irq;
    wr(PCS_MODE_OFS, 32'h2); chk(irq, 1);
    nx(3); chk(wan, 1);
    chk(rts, RT_WAN);
    wr(PMA_CTRL_OFS, 32'h11); chk(irq, 0);
    nx(3); chk(wan, 0);
    chk(rts, RT_LAN);
    wr(PMA_CTRL_OFS, 32'h0F); nx(3); chk(lts, 1);
    chk(rrs, 1);
    chk(rts, RT_LINE);
    wr(PMA_CTRL_OFS, 32'h1); wr(PCS_MODE_OFS, 32'h0);
    wr(PCS_TYPE_OFS, 32'h1); chk(irq, 1);
    nx(3); chk(wan, 1);
    wr(PCS_TYPE_OFS, 32'h0); nx(3); chk(wan, 0);
endtask
task automatic t_data;
    nx(3); p = txw; nx(0); chk(sto, p);
    chk(stv, 1);
    wr(LOOP_CTRL_OFS, 32'h0); nx(3); p = srw; nx(0); chk(sto, p);
    chk(egr, p);
    wr(PMA_CTRL_OFS, 32'h0); wr(LOOP_CTRL_OFS, 32'h0400); nx(3); p = {<<{txw}}; nx(0);
    chk(sto, p);
    wr(PMA_CTRL_OFS, 32'h1); wr(LOOP_CTRL_OFS, 32'h0410); nx(3); p = xrw; nx(0);
    chk(sto, IDLE_PATTERN);
    chk(egr, p);
    @(posedge mclk); pin[PIN_TX_EN] <= 0; nx(6); chk(sto, ALL_ZEROS);
endtask
initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    tally_and_finish;
end
initial begin
    repeat (10) @(posedge mclk);
    reset <= 0;
    t_reset; $display("reset test done");
    t_regs; $display("register loop test done");
    t_pins; $display("pin loop test done");
    t_irq; $display("interrupt and wan test done");
    t_data; $display("datapath test done");
    tally_and_finish;
end
endmodule
